// >>> common/gt16_pkg.sv
/*
  gt16_pkg: register map, field positions, reset values and prescaler
  limits of the 16-bit general timer.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
package gt16_pkg;
  localparam logic [7:0] GT16_CTRL_OFF = 8'h00;
  localparam logic [7:0] GT16_COUNT_OFF = 8'h04;
  localparam logic [7:0] GT16_PERIOD_OFF = 8'h08;
  localparam logic [7:0] GT16_STAT_OFF = 8'h0C;
  localparam logic [7:0] GT16_MASK_OFF = 8'h10;
  localparam logic [7:0] GT16_IRQC_OFF = 8'h14;

  localparam int GT16_ON_BIT = 15;
  localparam int GT16_GATE_BIT = 6;
  localparam int GT16_PS_LO = 4;
  localparam int GT16_SYNC_BIT = 2;
  localparam int GT16_CS_BIT = 1;
  localparam int GT16_IEN_BIT = 0;
  localparam int GT16_PRIO_LO = 1;
  localparam int GT16_ST_MATCH = 0;
  localparam int GT16_ST_GATE = 1;

  localparam logic [15:0] GT16_COUNT_RST = 16'h0000;
  localparam logic [15:0] GT16_PERIOD_RST = 16'hFFFF;
  localparam logic [1:0] GT16_STAT_RST = 2'h0;
  localparam logic [1:0] GT16_PS_RST = 2'h0;
  localparam logic [2:0] GT16_PRIO_RST = 3'h0;

  // prescaler terminal counts: ratios 1, 8, 64 and 256
  localparam logic [7:0] GT16_PS_LIM1 = 8'h00;
  localparam logic [7:0] GT16_PS_LIM8 = 8'h07;
  localparam logic [7:0] GT16_PS_LIM64 = 8'h3F;
  localparam logic [7:0] GT16_PS_LIM256 = 8'hFF;

  typedef enum logic [1:0] {
    GT16_SRC_INT = 2'b00,
    GT16_SRC_SYNC = 2'b01,
    GT16_SRC_ASYNC = 2'b10
  } gt16_src_t;

  function automatic logic [7:0] gt16_ps_limit(input logic [1:0] sel);
    case (sel)
      2'b00: gt16_ps_limit = GT16_PS_LIM1;
      2'b01: gt16_ps_limit = GT16_PS_LIM8;
      2'b10: gt16_ps_limit = GT16_PS_LIM64;
      default: gt16_ps_limit = GT16_PS_LIM256;
    endcase
  endfunction
endpackage

// >>> common/gt16_tick_if.sv
/*
  gt16_tick_if: configuration and count strobes between the timer core
  and its clock front end. Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface gt16_tick_if;
  import gt16_pkg::*;
  logic on;
  logic [1:0] ps_sel;
  gt16_src_t src;
  logic gate_en;
  logic tick;
  logic gate_fall;
  modport front (input on, input ps_sel, input src, input gate_en,
                 output tick, output gate_fall);
  modport core (output on, output ps_sel, output src, output gate_en,
                input tick, input gate_fall);
endinterface

// >>> rtl/gt16_front.sv
/*
  gt16_front: synchronises the external clock and gate pins, picks the
  count source and divides it by the prescaler into one-cycle ticks.
  Assumes the core drives the configuration side of gt16_tick_if.
*/
`timescale 1ns/1ps
module gt16_front (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_clk_pin,
  input wire logic gate_pin,
  input wire logic dev_sleep,
  gt16_tick_if.front tif
);
  import gt16_pkg::*;

  logic clk_s1_r, clk_s2_r, clk_d_r;
  logic gate_s1_r, gate_s2_r, gate_d_r;
  logic [7:0] ps_cnt_r;
  logic [7:0] ps_lim;
  logic ext_rise;
  logic raw;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_d_r <= 1'b0;
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      clk_s1_r <= ext_clk_pin;
      clk_s2_r <= clk_s1_r;
      clk_d_r <= clk_s2_r;
      gate_s1_r <= gate_pin;
      gate_s2_r <= gate_s1_r;
      gate_d_r <= gate_s2_r;
    end
  end

  assign ext_rise = clk_s2_r & ~clk_d_r;
  assign tif.gate_fall = tif.gate_en & gate_d_r & ~gate_s2_r;
  assign ps_lim = gt16_ps_limit(tif.ps_sel);

  // only the asynchronous counter keeps counting once the core clock sleeps
  always_comb begin
    case (tif.src)
      GT16_SRC_INT: raw = ~dev_sleep & (~tif.gate_en | gate_s2_r);
      GT16_SRC_SYNC: raw = ext_rise & ~dev_sleep;
      GT16_SRC_ASYNC: raw = ext_rise;
      default: raw = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !tif.on) begin
      ps_cnt_r <= 8'h00;
    end else if (raw) begin
      ps_cnt_r <= (ps_cnt_r >= ps_lim) ? 8'h00 : ps_cnt_r + 8'h01;
    end
  end

  assign tif.tick = tif.on & raw & (ps_cnt_r >= ps_lim);

  ext_sync_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tif.tick && tif.src != GT16_SRC_INT)
      |-> ($past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3)))
    else $error("external count without synchronised rising edge");
  sleep_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (dev_sleep && tif.src != GT16_SRC_ASYNC) |-> !tif.tick)
    else $error("count tick while sleeping in a synchronous mode");
  gate_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tif.src == GT16_SRC_INT && tif.gate_en && !$past(gate_pin, 2)) |-> !tif.tick)
    else $error("gated timer counted with gate low");
  prescale_eight_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tif.tick && tif.ps_sel == 2'b01) |=> (!tif.tick || tif.ps_sel != 2'b01) [*7])
    else $error("divide by eight ticked early");
endmodule // gt16_front

// >>> rtl/gt16_timer.sv
/*
  gt16_timer: 16-bit general timer with APB register access, period
  match and gate falling edge interrupts.
  Assumes a single 40 MHz sys_clk, synchronous active-high rst, and
  external clock and gate pins asynchronous to sys_clk.
*/
// The APB register port and the address map were chosen for this implementation.
// Function
// - a 16-bit counter usable as clock time base or interval timer
// - counts internal clock, synchronised external clock, or asynchronous external clock
// - gated mode counts the internal clock only while gate is high; gate fall raises interrupt
// - counter equal to period value raises interrupt request
// - counting may continue during CPU idle and device sleep
// - two-bit prescale select picks the count clock divide ratio
// - source select picks internal or external clock; gate bit enables gating
// - sync select chooses synchronised or asynchronous external counting
// - interrupts reach CPU only when enabled; three-bit priority field
`timescale 1ns/1ps
module gt16_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_pin,
  input wire logic gate_pin,
  input wire logic cpu_idle,
  input wire logic dev_sleep,
  output logic irq,
  output logic [2:0] timer_irq_priority
);
  import gt16_pkg::*;

  gt16_tick_if tif ();

  gt16_front u_front (
    .sys_clk(sys_clk),
    .rst(rst),
    .ext_clk_pin(ext_clk_pin),
    .gate_pin(gate_pin),
    .dev_sleep(dev_sleep),
    .tif(tif)
  );

  // control fields
  logic timer_on_r;
  logic [1:0] prescale_select_r;
  logic clock_source_select_r;
  logic gate_accumulate_enable_r;
  logic ext_clock_sync_select_r;
  logic timer_irq_enable_r;
  logic [2:0] timer_irq_priority_r;

  // counter, period and interrupt state
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] period_value_r;
  logic [1:0] stat_r;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;
  logic [1:0] mask_r;
  logic [31:0] prdata_r;

  // bus strobes
  logic setup_rd;
  logic access;
  logic wr_en;
  logic rd_acc;
  logic match;
  logic count_ld;
  logic ctrl_ld;
  logic period_ld;
  logic irqc_ld;

  function automatic logic gt16_addr_ok(input logic [7:0] a);
    gt16_addr_ok = (a == GT16_CTRL_OFF) || (a == GT16_COUNT_OFF) ||
                   (a == GT16_PERIOD_OFF) || (a == GT16_STAT_OFF) ||
                   (a == GT16_MASK_OFF) || (a == GT16_IRQC_OFF);
  endfunction

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_en && (paddr == off);
  endfunction

  assign setup_rd = psel & ~penable & ~pwrite;
  assign access = psel & penable;
  assign wr_en = access & pwrite & gt16_addr_ok(paddr);
  assign rd_acc = access & ~pwrite;
  // named load strobes keep the bus decode out of the assertions below
  assign count_ld = wr_hit(GT16_COUNT_OFF);
  assign ctrl_ld = wr_hit(GT16_CTRL_OFF);
  assign period_ld = wr_hit(GT16_PERIOD_OFF);
  assign irqc_ld = wr_hit(GT16_IRQC_OFF);

  // zero wait states: read data is captured during the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & ~gt16_addr_ok(paddr);

  assign tif.on = timer_on_r;
  assign tif.ps_sel = prescale_select_r;
  assign tif.gate_en = gate_accumulate_enable_r;

  // internal source ignores the sync select; external splits on it
  always_comb begin
    if (!clock_source_select_r) begin
      tif.src = GT16_SRC_INT;
    end else if (ext_clock_sync_select_r) begin
      tif.src = GT16_SRC_SYNC;
    end else begin
      tif.src = GT16_SRC_ASYNC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_on_r <= 1'b0;
      prescale_select_r <= GT16_PS_RST;
      clock_source_select_r <= 1'b0;
      gate_accumulate_enable_r <= 1'b0;
      ext_clock_sync_select_r <= 1'b0;
    end else if (wr_hit(GT16_CTRL_OFF)) begin
      timer_on_r <= pwdata[GT16_ON_BIT];
      prescale_select_r <= pwdata[GT16_PS_LO +: 2];
      clock_source_select_r <= pwdata[GT16_CS_BIT];
      gate_accumulate_enable_r <= pwdata[GT16_GATE_BIT];
      ext_clock_sync_select_r <= pwdata[GT16_SYNC_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_irq_enable_r <= 1'b0;
      timer_irq_priority_r <= GT16_PRIO_RST;
    end else if (wr_hit(GT16_IRQC_OFF)) begin
      timer_irq_enable_r <= pwdata[GT16_IEN_BIT];
      timer_irq_priority_r <= pwdata[GT16_PRIO_LO +: 3];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      period_value_r <= GT16_PERIOD_RST;
    end else if (wr_hit(GT16_PERIOD_OFF)) begin
      period_value_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_r <= GT16_STAT_RST;
    end else if (wr_hit(GT16_MASK_OFF)) begin
      mask_r <= pwdata[1:0];
    end
  end

  // a match is only acted on when a count arrives, so a period of zero
  // holds the counter at zero and flags every count
  assign match = tif.tick && (count_r == period_value_r);

  always_comb begin
    if (match) begin
      count_nxt = GT16_COUNT_RST;
    end else begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // a software load wins over a count landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= GT16_COUNT_RST;
    end else if (wr_hit(GT16_COUNT_OFF)) begin
      count_r <= pwdata[15:0];
    end else if (tif.tick) begin
      count_r <= count_nxt;
    end
  end

  // cpu_idle has no effect: the timer keeps running while the core idles
  always_comb begin
    stat_set = 2'b00;
    stat_set[GT16_ST_MATCH] = match;
    stat_set[GT16_ST_GATE] = tif.gate_fall;
  end

  // clear only what the setup cycle captured: a flag raised between the
  // setup and access edges was never returned, so it must survive the read
  assign stat_clr = (rd_acc && paddr == GT16_STAT_OFF) ? prdata_r[1:0] : 2'b00;

  // new events win over the read that clears the flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_r <= GT16_STAT_RST;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  assign irq = timer_irq_enable_r & |(stat_r & mask_r);
  assign timer_irq_priority = timer_irq_priority_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_r <= 32'h00000000;
      if (paddr == GT16_CTRL_OFF) begin
        prdata_r[GT16_ON_BIT] <= timer_on_r;
        prdata_r[GT16_GATE_BIT] <= gate_accumulate_enable_r;
        prdata_r[GT16_PS_LO +: 2] <= prescale_select_r;
        prdata_r[GT16_SYNC_BIT] <= ext_clock_sync_select_r;
        prdata_r[GT16_CS_BIT] <= clock_source_select_r;
      end else if (paddr == GT16_COUNT_OFF) begin
        prdata_r[15:0] <= count_r;
      end else if (paddr == GT16_PERIOD_OFF) begin
        prdata_r[15:0] <= period_value_r;
      end else if (paddr == GT16_STAT_OFF) begin
        prdata_r[1:0] <= stat_r;
      end else if (paddr == GT16_MASK_OFF) begin
        prdata_r[1:0] <= mask_r;
      end else if (paddr == GT16_IRQC_OFF) begin
        prdata_r[GT16_IEN_BIT] <= timer_irq_enable_r;
        prdata_r[GT16_PRIO_LO +: 3] <= timer_irq_priority_r;
      end
    end
  end

  assign prdata = prdata_r;

  match_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tif.tick && count_r == period_value_r && !count_ld)
      |=> (count_r == 16'h0000) && stat_r[GT16_ST_MATCH])
    else $error("period match did not wrap to zero and flag");
  count_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tif.tick && count_r != period_value_r && !count_ld)
      |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance by one on a tick");
  count_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!tif.tick && !count_ld) |=> $stable(count_r))
    else $error("counter moved without a tick or a load");
  stop_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !timer_on_r |-> !tif.tick)
    else $error("tick while timer is off");
  match_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(stat_r[GT16_ST_MATCH]) |-> $past(tif.tick) &&
      ($past(count_r) == $past(period_value_r)))
    else $error("match flag set without a period match");
  gate_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    tif.gate_fall |=> stat_r[GT16_ST_GATE])
    else $error("gate falling edge did not set its flag");
  irq_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_irq_enable_r && stat_r[GT16_ST_MATCH] && mask_r[GT16_ST_MATCH]) |-> irq)
    else $error("interrupt output disagrees with enable and flags");
  irq_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !timer_irq_enable_r |-> !irq)
    else $error("interrupt raised while disabled");
  src_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    !clock_source_select_r |-> tif.src == GT16_SRC_INT)
    else $error("internal source not selected");
  sync_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clock_source_select_r && !ext_clock_sync_select_r) |-> tif.src == GT16_SRC_ASYNC)
    else $error("asynchronous external source not selected");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_acc && paddr == GT16_STAT_OFF && !match && !tif.gate_fall)
      |=> (stat_r & $past(prdata_r[1:0])) == 2'b00)
    else $error("status read did not clear the flags");
  rd_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    (setup_rd && paddr == GT16_COUNT_OFF) |=> prdata[15:0] == $past(count_r))
    else $error("count read returned the wrong value");
  set_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    match |=> stat_r[GT16_ST_MATCH])
    else $error("match event lost against a status read");
  count_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    count_ld |=> count_r == $past(pwdata[15:0]))
    else $error("count load did not win over a tick");
  ctrl_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_ld |=> timer_on_r == $past(pwdata[GT16_ON_BIT]))
    else $error("timer on bit not taken from the write");
  period_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    period_ld |=> period_value_r == $past(pwdata[15:0]))
    else $error("period value not taken from the write");
  prio_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    irqc_ld |=> timer_irq_priority == $past(pwdata[GT16_PRIO_LO +: 3]))
    else $error("priority output not taken from the write");
endmodule // gt16_timer

// >>> testbench/general_timer_16bit_test.sv
/*
  general_timer_16bit_test: self-checking bench for gt16_timer over APB.
  Assumes the pin model drives the external clock and gate.
*/
`timescale 1ns/1ps
module general_timer_16bit_test;
  import gt16_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpu_idle = 1'b0;
  logic dev_sleep = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, ext_clk_pin, gate_pin;
  logic [2:0] timer_irq_priority;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] offs [6] = '{GT16_CTRL_OFF, GT16_COUNT_OFF, GT16_PERIOD_OFF,
                           GT16_STAT_OFF, GT16_MASK_OFF, GT16_IRQC_OFF};
  logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0};
  logic [31:0] d, d2;
  logic e, bad;
  logic [2:0] pr;
  int p, n, t0, t1;

  gt16_timer i_gt16_timer (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin),
    .cpu_idle(cpu_idle), .dev_sleep(dev_sleep), .irq(irq),
    .timer_irq_priority(timer_irq_priority));
  gt16_pins_model i_gt16_pins_model (.sys_clk(sys_clk), .ext_clk_pin(ext_clk_pin),
    .gate_pin(gate_pin));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic int ratio(input int sel);
    case (sel)
      0: return 1;
      1: return 8;
      2: return 64;
      default: return 256;
    endcase
  endfunction

  function automatic logic [31:0] ctrl(input int on, g, ps, sy, cs);
    return (32'(on) << GT16_ON_BIT) | (32'(g) << GT16_GATE_BIT) |
      (32'(ps) << GT16_PS_LO) | (32'(sy) << GT16_SYNC_BIT) | (32'(cs) << GT16_CS_BIT);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, v, x, y);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic y;
    apb(1'b0, a, 32'h0, v, y);
  endtask

  task automatic wait_irq(output int t);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (irq !== 1'b1 && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 5000) fail_count++;
    t = cyc;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    close_out;
  end

  initial begin
    void'($urandom(57180));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], d);
      check(d, rstv[i]);
    end
    apb(1'b0, 8'h18, 32'h0, d, e);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);
    d2 = $urandom;
    wr(GT16_PERIOD_OFF, d2);
    rd(GT16_PERIOD_OFF, d);
    check(d, {16'h0, d2[15:0]});
    pr = 3'($urandom % 8);
    wr(GT16_IRQC_OFF, {28'h0, pr, 1'b1});
    // the write lands at the access edge; look once it has settled
    @(posedge sys_clk);
    check({29'h0, timer_irq_priority}, {29'h0, pr});
    wr(GT16_MASK_OFF, 32'h1);
    // match interval is (period+1) times the prescale ratio
    for (int ps = 0; ps < 4; ps++) begin
      p = 6 + $urandom % 6;
      wr(GT16_CTRL_OFF, 32'h0);
      wr(GT16_COUNT_OFF, 32'h0);
      wr(GT16_PERIOD_OFF, 32'(p));
      rd(GT16_STAT_OFF, d);
      wr(GT16_CTRL_OFF, ctrl(1, 0, ps, 0, 0));
      wait_irq(t0);
      rd(GT16_STAT_OFF, d);
      check(d, 32'h1);
      wait_irq(t1);
      check(32'(t1 - t0), 32'((p + 1) * ratio(ps)));
    end
    wr(GT16_CTRL_OFF, ctrl(1, 0, 0, 0, 0));
    for (int k = 0; k < 2; k++) begin
      wr(GT16_MASK_OFF, 32'(k));
      wr(GT16_IRQC_OFF, {28'h0, pr, 1'(1 - k)});
      rd(GT16_STAT_OFF, d);
      bad = 1'b0;
      repeat (40) begin
        @(posedge sys_clk);
        if (irq !== 1'b0) bad = 1'b1;
      end
      check({31'h0, bad}, 32'h0);
      rd(GT16_STAT_OFF, d);
      check(d, 32'h1);
    end
    wr(GT16_CTRL_OFF, 32'h0);
    rd(GT16_COUNT_OFF, d);
    repeat (20) @(posedge sys_clk);
    rd(GT16_COUNT_OFF, d2);
    check(d2, d);
    wr(GT16_PERIOD_OFF, 32'h0000FFFF);
    wr(GT16_COUNT_OFF, 32'h0);
    cpu_idle <= 1'b1;
    wr(GT16_CTRL_OFF, ctrl(1, 0, 0, 0, 0));
    repeat (50) @(posedge sys_clk);
    rd(GT16_COUNT_OFF, d);
    check({31'h0, d >= 32'd50}, 32'h1);
    cpu_idle <= 1'b0;
    // sync awake, async asleep, sync asleep
    for (int m = 0; m < 3; m++) begin
      wr(GT16_CTRL_OFF, 32'h0);
      wr(GT16_COUNT_OFF, 32'h0);
      dev_sleep <= (m != 0);
      wr(GT16_CTRL_OFF, ctrl(1, 0, 0, (m != 1), 1));
      n = 3 + $urandom % 8;
      i_gt16_pins_model.send(n, 3);
      repeat (8) @(posedge sys_clk);
      rd(GT16_COUNT_OFF, d);
      check(d, (m == 2) ? 32'h0 : 32'(n));
    end
    dev_sleep <= 1'b0;
    wr(GT16_CTRL_OFF, 32'h0);
    wr(GT16_COUNT_OFF, 32'h0);
    wr(GT16_MASK_OFF, 32'h2);
    wr(GT16_IRQC_OFF, {28'h0, pr, 1'b1});
    rd(GT16_STAT_OFF, d);
    wr(GT16_CTRL_OFF, ctrl(1, 1, 0, 0, 0));
    repeat (20) @(posedge sys_clk);
    rd(GT16_COUNT_OFF, d);
    check(d, 32'h0);
    i_gt16_pins_model.set_gate(1'b1);
    repeat (10) @(posedge sys_clk);
    i_gt16_pins_model.set_gate(1'b0);
    repeat (6) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    rd(GT16_STAT_OFF, d);
    check(d, 32'h2);
    rd(GT16_STAT_OFF, d);
    check(d, 32'h0);
    rd(GT16_COUNT_OFF, d);
    rd(GT16_COUNT_OFF, d2);
    check({31'h0, d != 32'h0}, 32'h1);
    check(d2, d);
    close_out;
  end
endmodule // general_timer_16bit_test

// >>> testbench/gt16_pins_model.sv
/*
  gt16_pins_model: drives the external count clock and gate pins of the
  timer. Assumes the bench calls its tasks just after a sys_clk edge.
*/
`timescale 1ns/1ps
module gt16_pins_model (
  input wire logic sys_clk,
  output logic ext_clk_pin,
  output logic gate_pin
);
  initial begin
    ext_clk_pin = 1'b0;
    gate_pin = 1'b0;
  end

  // clock stands low between bursts so no stray edge gets counted
  task automatic send(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge sys_clk);
      ext_clk_pin <= 1'b1;
      repeat (half) @(posedge sys_clk);
      ext_clk_pin <= 1'b0;
    end
  endtask

  task automatic set_gate(input logic level);
    @(posedge sys_clk);
    gate_pin <= level;
  endtask
endmodule // gt16_pins_model
